//--- shared/bdma_pkg.sv
// Shared constants for the banked data memory addressing block
package bdma_pkg;

    // ********************************************************
    // Address space geometry
    // ********************************************************
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int OFFS_W = 8;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int MEM_BYTES = 4096;
    localparam int USER_BYTES = 3808;

    // ********************************************************
    // Fixed locations and access bank map
    // ********************************************************
    localparam logic [11:0] SFR_BASE = 12'hf60;
    localparam logic [11:0] BP_ADDR = 12'hfe0;
    localparam logic [11:0] PCL_ADDR = 12'hff9;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
    localparam logic [3:0] BP_RESET = 4'h0;
    localparam logic [3:0] BP_UNUSED = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ********************************************************
    // Opcode patterns of the decoded word
    // ********************************************************
    localparam logic [3:0] SECOND_TAG = 4'hf;
    localparam logic [3:0] FAM_TAG = 4'hc;
    localparam logic [6:0] CALL_TAG = 7'h76;
    localparam logic [7:0] JUMP_TAG = 8'hef;
    localparam logic [9:0] PLL_TAG = 10'h3b8;
    localparam logic [11:0] BLL_TAG = 12'h010;

    // ********************************************************
    // Instruction quarters and current kinds
    // ********************************************************
    typedef enum logic [1:0] {
        Q1 = 2'b00,
        Q2 = 2'b01,
        Q3 = 2'b10,
        Q4 = 2'b11
    } bdma_quarter_e;

    typedef enum logic [2:0] {
        K_IDLE = 3'b000,
        K_OP = 3'b001,
        K_FAM1 = 3'b010,
        K_FAM2 = 3'b011,
        K_TWO1 = 3'b100,
        K_LIT2 = 3'b101,
        K_NOP2 = 3'b110,
        K_BLL = 3'b111
    } bdma_kind_e;

endpackage

//--- hdl/bdma_core.sv
// Data memory addressing, bank pointer and two-word instruction handling
`timescale 1ns/100ps

// Overview of operation
// RULE1: Call, full-address move, jump and pointer-literal load take a second word.
// RULE2: A second word carries 1111 on top and a 12-bit literal below.
// RULE3: A second word right after its first word hands its literal over.
// RULE4: A 1111-tagged word executed alone behaves as a no-operation.
// RULE5: Data addresses are 12 bits: 16 banks of 256 bytes.
// RULE6: All banks exist; 3808 bytes of user memory are provided.
// RULE7: Reading an unimplemented location returns zero.
// RULE8: Banked address is bank pointer on top, opcode offset below.
// RULE9: Bank pointer keeps bits 3..0 only; upper bits read zero.
// RULE10: The bank-literal load instruction loads the bank pointer directly.
// RULE11: Writes to unimplemented space are dropped; flags still update.
// RULE12: Full-address move uses its own 12-bit addresses, ignoring bank pointer.
// RULE13: Writing bank 15 offset F9h modifies the program counter low byte.
// RULE14: Access map sends 00h-5Fh to bank 0, 60h-FFh to bank 15.
// RULE15: Access-select 1 addresses through bank pointer plus opcode offset.
// RULE16: Access-select 0 uses the access map, ignoring the bank pointer.
// RULE17: Access map accesses finish within one instruction cycle.
// RULE18: Extended-set select changes the access map for low offsets.
// RULE19: Operands are read in quarter two, results written in quarter four.
// RULE20: User memory is never cleared by any reset.
// RULE21: A lone second word makes no memory access and no flag change.
module bdma_core #(
    parameter int USER_BYTES = bdma_pkg::USER_BYTES,
    parameter logic [11:0] SFR_BASE = bdma_pkg::SFR_BASE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Instruction from decode, sampled in quarter one except extended set select and index base, which are used live
    input wire logic instr_valid,
    input wire logic instr_skip,
    input wire logic [15:0] instr_word,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic access_sel,
    input wire logic extended_set_select,
    input wire logic [11:0] index_base,
    // Result from execute, sampled in quarter four
    input wire logic [7:0] wr_data,
    // Cycle phase
    output logic [1:0] quarter,
    // Operand and literal towards execute
    output logic [7:0] rd_data,
    output logic [11:0] literal,
    output logic literal_valid,
    output logic nop_exec,
    output logic flag_update,
    output logic [7:0] bank_pointer,
    // Program counter low byte write
    output logic pcl_wr,
    output logic [7:0] pcl_data,
    // Special function area port
    output logic [11:0] sfr_addr,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata
);

    // ********************************************************
    // State
    // ********************************************************
    bdma_pkg::bdma_quarter_e q_q, q_d;
    bdma_pkg::bdma_kind_e kind_q, kind_d;
    logic [15:0] word_q;
    logic rd_q, wr_q, asel_q;
    logic pend_q, pend_fam_q;
    logic [3:0] bp_q;
    logic [7:0] rd_data_q;
    logic [11:0] lit_q;
    logic lit_valid_q, nop_q, flag_q, pcl_wr_q;
    logic [7:0] pcl_data_q;
    // No reset on the array: contents survive every reset
    logic [7:0] user_mem [USER_BYTES]; // [RULE6] [RULE20]

    // ********************************************************
    // Word classification
    // ********************************************************
    wire take = (q_q == bdma_pkg::Q1) && instr_valid;
    wire is_second = instr_word[15:12] == bdma_pkg::SECOND_TAG; // [RULE2]
    wire is_fam = instr_word[15:12] == bdma_pkg::FAM_TAG;
    wire is_call = instr_word[15:9] == bdma_pkg::CALL_TAG;
    wire is_jump = instr_word[15:8] == bdma_pkg::JUMP_TAG;
    wire is_pll = instr_word[15:6] == bdma_pkg::PLL_TAG;
    wire is_bll = instr_word[15:4] == bdma_pkg::BLL_TAG;
    wire is_two = is_call || is_jump || is_pll; // [RULE1]

    // ********************************************************
    // Address formation
    // ********************************************************
    wire [7:0] offs = word_q[7:0];
    wire [11:0] banked_addr = {bp_q, offs}; // [RULE8] [RULE15]
    wire acc_low = offs < bdma_pkg::ACC_SPLIT;
    // Extended set turns the low access window into base-indexed slots
    wire [11:0] idx_addr = index_base + {4'h0, offs}; // [RULE18]
    wire [11:0] acc_low_addr = extended_set_select ? idx_addr :
        {bdma_pkg::ACC_LOW_BANK, offs};
    wire [11:0] acc_addr = acc_low ? acc_low_addr :
        {bdma_pkg::ACC_HIGH_BANK, offs}; // [RULE14] [RULE16]
    wire fam_kind = (kind_q == bdma_pkg::K_FAM1) ||
        (kind_q == bdma_pkg::K_FAM2);
    // Full-address move carries its source address in the first word, its destination in the second
    wire [11:0] addr = fam_kind ? word_q[11:0] :
        (asel_q ? banked_addr : acc_addr); // [RULE12] [RULE5]

    // ********************************************************
    // Region decode
    // ********************************************************
    wire in_user = {20'h0, addr} < USER_BYTES; // [RULE6]
    wire in_bp = addr == bdma_pkg::BP_ADDR;
    wire in_sfr = (addr >= SFR_BASE) && !in_bp;
    wire in_pcl = addr == bdma_pkg::PCL_ADDR;
    wire [7:0] bp_read = {bdma_pkg::BP_UNUSED, bp_q}; // [RULE9]
    wire [7:0] user_read = in_user ? user_mem[addr] :
        bdma_pkg::READ_ZERO;
    wire [7:0] read_mux = in_bp ? bp_read :
        (in_sfr ? sfr_rdata : user_read); // [RULE7] [RULE11]

    // ********************************************************
    // Access strobes per quarter
    // ********************************************************
    wire op_rd = (kind_q == bdma_pkg::K_OP) && rd_q;
    wire do_rd = (q_q == bdma_pkg::Q2) &&
        (op_rd || kind_q == bdma_pkg::K_FAM1); // [RULE19] [RULE17]
    wire op_wr = (kind_q == bdma_pkg::K_OP) && wr_q;
    wire do_wr = (q_q == bdma_pkg::Q4) &&
        (op_wr || kind_q == bdma_pkg::K_FAM2); // [RULE19]
    // Move result is the byte read in quarter two of the previous instruction cycle
    wire [7:0] wdata = (kind_q == bdma_pkg::K_FAM2) ? rd_data_q : wr_data;
    wire bll_now = (q_q == bdma_pkg::Q4) &&
        (kind_q == bdma_pkg::K_BLL);
    wire flag_now = (q_q == bdma_pkg::Q4) &&
        (kind_q == bdma_pkg::K_OP); // [RULE11] [RULE21]

    // ********************************************************
    // Next kind on quarter one
    // ********************************************************
    always_comb begin
        q_d = bdma_pkg::bdma_quarter_e'(q_q + 2'b01);
        kind_d = kind_q;
        if (take) begin
            if (instr_skip) begin
                kind_d = bdma_pkg::K_IDLE;
            end else if (is_second) begin
                if (!pend_q) begin
                    kind_d = bdma_pkg::K_NOP2; // [RULE4] [RULE21]
                end else if (pend_fam_q) begin
                    kind_d = bdma_pkg::K_FAM2;
                end else begin
                    kind_d = bdma_pkg::K_LIT2; // [RULE3]
                end
            end else if (is_fam) begin
                kind_d = bdma_pkg::K_FAM1;
            end else if (is_two) begin
                kind_d = bdma_pkg::K_TWO1; // [RULE1]
            end else if (is_bll) begin
                kind_d = bdma_pkg::K_BLL;
            end else begin
                kind_d = bdma_pkg::K_OP;
            end
        end else if (q_q == bdma_pkg::Q1) begin
            kind_d = bdma_pkg::K_IDLE;
        end
    end

    // ********************************************************
    // Phase, instruction and pairing registers
    // ********************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            q_q <= bdma_pkg::Q1;
            kind_q <= bdma_pkg::K_IDLE;
            word_q <= 16'h0000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            asel_q <= 1'b0;
        end else begin
            q_q <= q_d;
            kind_q <= kind_d;
            if (take) begin
                word_q <= instr_word;
                rd_q <= mem_rd;
                wr_q <= mem_wr;
                asel_q <= access_sel;
            end
        end
    end

    // A skipped or unrelated word breaks the pairing
    always_ff @(posedge clk) begin
        if (srst) begin
            pend_q <= 1'b0;
            pend_fam_q <= 1'b0;
        end else if (take) begin
            pend_q <= !instr_skip && !is_second &&
                (is_fam || is_two); // [RULE1] [RULE4]
            pend_fam_q <= !instr_skip && is_fam;
        end
    end

    // ********************************************************
    // Literal and no-operation outputs
    // ********************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            lit_q <= 12'h000;
            lit_valid_q <= 1'b0;
            nop_q <= 1'b0;
        end else if (q_q == bdma_pkg::Q1) begin
            lit_q <= instr_word[11:0];
            lit_valid_q <= kind_d == bdma_pkg::K_LIT2 ||
                kind_d == bdma_pkg::K_FAM2; // [RULE3]
            nop_q <= kind_d == bdma_pkg::K_NOP2; // [RULE4]
        end
    end

    // ********************************************************
    // Bank pointer
    // ********************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            bp_q <= bdma_pkg::BP_RESET;
        end else if (bll_now) begin
            bp_q <= word_q[3:0]; // [RULE10]
        end else if (do_wr && in_bp) begin
            bp_q <= wdata[3:0]; // [RULE9]
        end
    end

    // ********************************************************
    // Operand read, flag and program counter strobes
    // ********************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_q <= bdma_pkg::READ_ZERO;
            flag_q <= 1'b0;
            pcl_wr_q <= 1'b0;
            pcl_data_q <= bdma_pkg::READ_ZERO;
        end else begin
            if (do_rd) begin
                rd_data_q <= read_mux; // [RULE7] [RULE19]
            end
            flag_q <= flag_now; // [RULE11]
            pcl_wr_q <= do_wr && in_pcl; // [RULE13]
            if (do_wr && in_pcl) begin
                pcl_data_q <= wdata;
            end
        end
    end

    // ********************************************************
    // User memory write
    // ********************************************************
    // Writes outside user space and the register areas fall away here
    always_ff @(posedge clk) begin
        if (do_wr && in_user) begin
            user_mem[addr] <= wdata; // [RULE11] [RULE20]
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign quarter = q_q;
    assign rd_data = rd_data_q;
    assign literal = lit_q;
    assign literal_valid = lit_valid_q;
    assign nop_exec = nop_q;
    assign flag_update = flag_q;
    assign bank_pointer = bp_read;
    assign pcl_wr = pcl_wr_q;
    assign pcl_data = pcl_data_q;
    assign sfr_addr = addr;
    assign sfr_rd = do_rd && in_sfr;
    assign sfr_wr = do_wr && in_sfr;
    assign sfr_wdata = wdata;

endmodule

//--- test/bdma_sfr_model.sv
// Model of the special function area behind the core
`timescale 1ns/100ps
module bdma_sfr_model (
    // Access from the core
    input wire logic clk,
    input wire logic [11:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    // Read answer
    output logic [7:0] sfr_rdata
);
    // ********************************************************
    // Register store
    // ********************************************************
    logic [7:0] regs [256] = '{default: 8'h00};
    logic [7:0] last = 8'h00;
    always @(posedge clk) begin
        if (sfr_wr) regs[sfr_addr[7:0]] <= sfr_wdata;
        if (sfr_rd) last <= sfr_rdata;
    end
    // Idle answer is never the last byte, so a late sample shows
    assign sfr_rdata = sfr_rd ? regs[sfr_addr[7:0]] : ~last;
endmodule

//--- test/bdma_core_chk.sv
// Concurrent checks on the ports of the addressing core
`timescale 1ns/100ps
module bdma_core_chk #(
    parameter int USER_BYTES = bdma_pkg::USER_BYTES,
    parameter logic [11:0] SFR_BASE = bdma_pkg::SFR_BASE
) (
    // Clock, reset and phase
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] quarter,
    // Decode results
    input wire logic [7:0] bank_pointer,
    input wire logic [11:0] literal,
    input wire logic literal_valid,
    input wire logic nop_exec,
    input wire logic flag_update,
    // Data side
    input wire logic pcl_wr,
    input wire logic [7:0] pcl_data,
    input wire logic [11:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata
);
    // ********************************************************
    // Properties
    // ********************************************************
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    quarter_step_a: assert property (
        !$past(srst) |-> quarter == $past(quarter) + 2'd1)
        else $error("quarter did not advance by one");
    bank_upper_a: assert property (bank_pointer[7:4] == 4'h0)
        else $error("bank pointer upper bits not zero");
    read_phase_a: assert property (sfr_rd |-> quarter == 2'd1 &&
        sfr_addr >= SFR_BASE && sfr_addr != 12'hfe0)
        else $error("special area read outside its phase or range");
    write_phase_a: assert property (sfr_wr |-> quarter == 2'd3)
        else $error("special area write outside quarter four");
    pcl_write_a: assert property (
        sfr_wr && sfr_addr == 12'hff9 |=> pcl_wr && pcl_data == $past(sfr_wdata))
        else $error("program counter low byte not written");
    literal_hold_a: assert property ($rose(literal_valid) |->
        quarter == 2'd1 ##1 (literal_valid && $stable(literal)) [*3])
        else $error("literal did not stand for the instruction");
    nop_quiet_a: assert property (
        nop_exec |-> !sfr_rd && !sfr_wr && !literal_valid)
        else $error("lone second word made an access");
    flag_timing_a: assert property (flag_update |->
        quarter == 2'd0 && $past(quarter) == 2'd3 && !nop_exec && !literal_valid)
        else $error("flag update at the wrong moment");
endmodule

bind bdma_core bdma_core_chk #(.USER_BYTES(USER_BYTES), .SFR_BASE(SFR_BASE))
    chk_u (.clk, .srst, .quarter, .bank_pointer, .literal, .literal_valid,
    .nop_exec, .flag_update, .pcl_wr, .pcl_data, .sfr_addr, .sfr_rd,
    .sfr_wr, .sfr_wdata);

//--- test/test_banked_data_memory_addressing.sv
// Self-checking bench for the banked data memory addressing core
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module test_banked_data_memory_addressing;
    // ********************************************************
    // Stimulus, reference model and checks
    // ********************************************************
    logic clk, srst, instr_valid, instr_skip, mem_rd, mem_wr, access_sel;
    logic extended_set_select, literal_valid, nop_exec, flag_update, pcl_wr;
    logic sfr_rd, sfr_wr, cfg_x, lv, nx;
    logic [1:0] quarter;
    logic [15:0] instr_word;
    logic [11:0] index_base, literal, sfr_addr, cfg_b, lit, a;
    logic [7:0] wr_data, rd_data, bank_pointer, pcl_data, sfr_wdata;
    logic [7:0] sfr_rdata, rdv, pcl_seen, d;
    logic [3:0] bp_m;
    logic [31:0] seed = 32'h050b2dd9;
    logic [15:0] fw [4] = '{16'hc123, 16'hec12, 16'hef34, 16'hee05};
    int mem_m [4096];
    int err_count, total_checks, flags, f0;
    bdma_core dut_u (.clk, .srst, .instr_valid, .instr_skip, .instr_word,
        .mem_rd, .mem_wr, .access_sel, .extended_set_select, .index_base,
        .wr_data, .quarter, .rd_data, .literal, .literal_valid, .nop_exec,
        .flag_update, .bank_pointer, .pcl_wr, .pcl_data, .sfr_addr, .sfr_rd,
        .sfr_wr, .sfr_wdata, .sfr_rdata);
    bdma_sfr_model sfr_u (.clk, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_wdata,
        .sfr_rdata);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Whole run is a few hundred cycles; this is ample margin
    initial begin
        #100000;
        err_count++;
        complete_run();
    end
    always @(negedge clk) begin
        if (flag_update === 1'b1) flags++;
        if (pcl_wr === 1'b1) pcl_seen = pcl_data;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] mdl_rd(input logic [11:0] x);
        if (x >= 12'hee0 && x < 12'hf60) return 8'h00;
        if (x == 12'hfe0) return {4'h0, bp_m};
        return 8'(mem_m[x]);
    endfunction
    task automatic mdl_wr(input logic [11:0] x, input logic [7:0] v);
        if (!(x >= 12'hee0 && x < 12'hf60)) mem_m[x] = v;
    endtask
    // c holds read, write, access-select and skip; entered at a falling edge
    task automatic run(input logic [15:0] w, input logic [3:0] c,
            input logic [7:0] v);
        while (quarter !== 2'd3) @(negedge clk);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        {mem_rd, mem_wr, access_sel, instr_skip} <= c;
        wr_data <= v;
        extended_set_select <= cfg_x;
        index_base <= cfg_b;
        @(posedge clk);
        instr_valid <= 1'b0;
        @(negedge clk);
        lv = literal_valid;
        nx = nop_exec;
        lit = literal;
        @(negedge clk);
        rdv = rd_data;
    endtask
    task automatic setb(input logic [3:0] b);
        run({12'h010, b}, 4'b0010, 8'h00);
        bp_m = b;
    endtask
    task automatic wr_at(input logic [11:0] x, input logic [7:0] v);
        setb(x[11:8]);
        run({8'h6e, x[7:0]}, 4'b0110, v);
        mdl_wr(x, v);
    endtask
    task automatic rd_at(input logic [11:0] x);
        setb(x[11:8]);
        run({8'h50, x[7:0]}, 4'b1010, 8'h00);
        `CHK("rd_data", mdl_rd(x), rdv)
    endtask
    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        srst = 1'b1;
        {instr_valid, instr_skip, mem_rd, mem_wr, access_sel, cfg_x} = '0;
        {extended_set_select, instr_word, index_base, wr_data, cfg_b} = '0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        `CHK("bank_pointer", 8'h00, bank_pointer)
        for (int k = 15; k >= 0; k--) begin
            setb(4'(k));
            repeat (2) @(negedge clk);
            `CHK("bank_pointer", {4'h0, bp_m}, bank_pointer)
        end
        for (int i = 0; i < 10; i++) begin
            a = 12'(rnd());
            if (a == 12'hfe0) a = 12'h0e0;
            wr_at(a, 8'(rnd()));
            rd_at(a);
        end
        setb(4'he);
        repeat (2) @(negedge clk);
        f0 = flags;
        run(16'h6ef0, 4'b0110, 8'h5a);
        // Flag pulse is counted on the quarter-one falling edge; wait past it
        repeat (3) @(negedge clk);
        `CHK("flag_count", 1, flags - f0)
        rd_at(12'hef0);
        setb(4'h5);
        d = 8'(rnd());
        run(16'h6e10, 4'b0100, d);
        mdl_wr(12'h010, d);
        rd_at(12'h010);
        run(16'h6e90, 4'b0100, ~d);
        mdl_wr(12'hf90, ~d);
        rd_at(12'hf90);
        cfg_x = 1'b1;
        cfg_b = 12'h200;
        run(16'h6e10, 4'b0100, d ^ 8'h33);
        cfg_x = 1'b0;
        mdl_wr(12'h210, d ^ 8'h33);
        rd_at(12'h210);
        wr_at(12'hff9, 8'h3c);
        repeat (3) @(negedge clk);
        `CHK("pcl_data", 8'h3c, pcl_seen)
        wr_at(12'h123, 8'ha5);
        setb(4'h7);
        foreach (fw[j]) begin
            run(fw[j], 4'b0010, 8'h00);
            run(16'hf456, 4'b0010, 8'h00);
            `CHK("literal", 12'h456, lit)
            `CHK("literal_valid", 1'b1, lv)
        end
        mdl_wr(12'h456, 8'ha5);
        rd_at(12'h456);
        repeat (3) @(negedge clk);
        f0 = flags;
        run(16'hc777, 4'b0011, 8'h00);
        run(16'hf123, 4'b0010, 8'h00);
        `CHK("nop_exec", 1'b1, nx)
        `CHK("literal_valid", 1'b0, lv)
        repeat (3) @(negedge clk);
        `CHK("flag_count", 0, flags - f0)
        rd_at(12'h123);
        complete_run();
    end
endmodule
